// ===== steer_fault_defines.vh
// Constants of the steering fault supervisor: register offsets, field
// positions, reset values, thresholds, fault table and timing.
// Included by bare name; definitions only.
`ifndef STEER_FAULT_DEFINES_VH
`define STEER_FAULT_DEFINES_VH

// Register offsets (word addresses of the plain register port)
`define REG_FAULTS        4'h0
`define REG_REPORT        4'h1
`define REG_TIMEOUT       4'h2
`define REG_IRQ_STATUS    4'h3
`define REG_IRQ_CLEAR     4'h4
`define REG_IRQ_ENABLE    4'h5

// Report register field positions
`define REP_CODE_LSB      0
`define REP_SUB_LSB       8
`define REP_TRAC_LSB      16
`define REP_STATE_LSB     18

// Interrupt bits
`define IRQ_SET_BIT       0
`define IRQ_CLR_BIT       1
`define IRQ_SHUT_BIT      2
`define IRQ_W             3

// Reset values
`define TIMEOUT_RST       16'h03e8
`define IRQ_EN_RST        3'h0

// Timing: millisecond tick for the fault steering timer
`define CLK_PERIOD_NS     5
`define TICK_PERIOD_NS    1000000
`define MS_CYCLES         (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

// Steer fault actions
`define STEER_WARN        2'h0
`define STEER_SHUT        2'h1
`define STEER_WARN_SHUT   2'h2
`define STEER_HOLD_SHUT   2'h3

// Traction fault action codes
`define TRAC_NONE         2'h0
`define TRAC_STOP         2'h1
`define TRAC_REDUCE       2'h2
`define TRAC_NOACT        2'h3

// Fault table size
`define NUM_FAULTS        9

// Thresholds: temperature in signed whole degC, voltage in 0.1 V
`define TEMP_UNDER_SET    8'shd8
`define TEMP_UNDER_CLR    8'shdd
`define TEMP_OVER_SET     8'sh5f
`define VOLT_UNDER        10'h078
`define VOLT_OVER         10'h28a
// 120 percent overcurrent as phase*5 > limit*6
`define OC_PHASE_MUL      16'h0005
`define OC_LIMIT_MUL      16'h0006
// 75 percent precharge as cap*4 < ksi*3
`define PRE_CAP_MUL       12'h004
`define PRE_KSI_MUL       12'h003

`endif

// ===== steer_fault_supervisor.v
// Steering fault supervisor: latches faults from detections and measured
// values, drives the steer action and the traction action code.
// Assumes measured values and traction_stopped come from logic on core_clk;
// hw_error, hw_overcurrent, meas_limit and keyswitch_input are pins.
// Operation
// - Warning fault keeps steering, only reports it
// - Shutdown fault stops steering, drops fault output
// - Warn-shutdown waits for traction stop or timeout
// - Hold-shutdown holds wheel, ignores operator until done
// - Each fault has code, sub-code, actions
// - Hardware error gives code 11.1, shutdown, stop
// - Hardware overcurrent gives code 12, latched
// - Phase current over 120 percent gives 12.5
// - Precharge below 75 percent gives 14.1
// - Heatsink -40C sets 15, above -35C clears
// - Heatsink 95C sets 16, warn then shutdown
// - Keyswitch or interlocked capacitor under 12V gives 17.1
// - Keyswitch or capacitor over 65V gives 18
// - Traction code: 0 none,1 stop,2 reduce,3 none
// - Emergency message on every fault set or clear
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "steer_fault_defines.vh"

module steer_fault_supervisor #(
	parameter MS_CYCLES = `MS_CYCLES,
	parameter CNT_W     = 18
) (
	// Clock and reset
	input  wire              core_clk,
	input  wire              reset,
	// Register port
	input  wire [3:0]        reg_addr,
	input  wire [31:0]       reg_wdata,
	input  wire              reg_wr,
	input  wire              reg_rd,
	output reg  [31:0]       reg_rdata_r,
	// Detection pins
	input  wire              hw_error,
	input  wire              hw_overcurrent,
	input  wire              meas_limit,
	input  wire              keyswitch_input,
	// Measured values
	input  wire [11:0]       phase_current,
	input  wire [11:0]       base_current_limit,
	input  wire              offset_invalid,
	input  wire              precharge_done,
	input  wire [9:0]        cap_voltage,
	input  wire [9:0]        keyswitch_voltage,
	input  wire              interlock_on,
	input  wire signed [7:0] heatsink_temp,
	// From traction side
	input  wire              traction_stopped,
	// Steering control
	output reg               steer_enable_r,
	output reg               hold_position_r,
	output reg               fault_output_r,
	// Fault report and emergency message
	output reg  [7:0]        fault_code_r,
	output reg  [7:0]        sub_code_r,
	output reg  [1:0]        traction_action_code_r,
	output reg               error_register_r,
	output reg               emcy_valid_r,
	// Interrupt
	output reg               irq_r
);

	localparam ST_RUN  = 2'h0;
	localparam ST_WARN = 2'h1;
	localparam ST_HOLD = 2'h2;
	localparam ST_SHUT = 2'h3;
	localparam NF      = `NUM_FAULTS;
	localparam IRQ_W_L = `IRQ_W - 1;

	// Fault table: code per index
	function [7:0] code_of;
		input [3:0] i;
		begin
			case (i)
				4'h0: code_of = 8'h0b;
				4'h1: code_of = 8'h0c;
				4'h2: code_of = 8'h0c;
				4'h3: code_of = 8'h0d;
				4'h4: code_of = 8'h0e;
				4'h5: code_of = 8'h0f;
				4'h6: code_of = 8'h10;
				4'h7: code_of = 8'h11;
				4'h8: code_of = 8'h12;
				default: code_of = 8'h00;
			endcase
		end
	endfunction

	// Sub-code per index; a dash is zero
	function [7:0] sub_of;
		input [3:0] i;
		begin
			case (i)
				4'h0: sub_of = 8'h01;
				4'h2: sub_of = 8'h05;
				4'h4: sub_of = 8'h01;
				4'h7: sub_of = 8'h01;
				default: sub_of = 8'h00;
			endcase
		end
	endfunction

	// Steer action per index
	function [1:0] steer_of;
		input [3:0] i;
		begin
			case (i)
				4'h5: steer_of = `STEER_WARN;
				4'h6: steer_of = `STEER_WARN_SHUT;
				default: steer_of = `STEER_SHUT;
			endcase
		end
	endfunction

	// Traction action per index
	function [1:0] trac_of;
		input [3:0] i;
		begin
			case (i)
				4'h5: trac_of = `TRAC_NOACT;
				default: trac_of = `TRAC_STOP;
			endcase
		end
	endfunction

	// Restriction rank of a traction code, stop highest
	function [1:0] trac_rank;
		input [1:0] c;
		begin
			case (c)
				`TRAC_STOP: trac_rank = 2'h3;
				`TRAC_REDUCE: trac_rank = 2'h2;
				`TRAC_NOACT: trac_rank = 2'h1;
				default: trac_rank = 2'h0;
			endcase
		end
	endfunction

	reg [2:0]       sync1_r;
	reg [2:0]       sync2_r;
	reg [NF-1:0]    faults_r;
	reg [NF-1:0]    faults_nxt;
	reg [NF-1:0]    set_v;
	reg [1:0]       state_r;
	reg [1:0]       state_nxt;
	reg [15:0]      timeout_r;
	reg [15:0]      timer_r;
	reg [CNT_W-1:0] tick_cnt_r;
	reg             tick_r;
	reg [2:0]       irq_stat_r;
	reg [2:0]       irq_en_r;
	reg [7:0]       code_nxt;
	reg [7:0]       sub_nxt;
	reg [1:0]       trac_nxt;
	reg             shut_any;
	reg             hold_any;
	reg             wts_any;
	reg [IRQ_W_L:0] irq_ev;
	integer         k;

	// Only the second flop of each synchroniser is read
	wire hw_err_s = sync2_r[0];
	wire hw_oc_s  = sync2_r[1];
	wire ks_on    = sync2_r[2];

	// Pins pass two flops; a ks bounce just reads as a power cycle
	always @(posedge core_clk) begin
		if (reset) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
		end else begin
			sync1_r <= {keyswitch_input, hw_overcurrent, hw_error};
			sync2_r <= sync1_r;
		end
	end

	reg meas1_r;
	reg meas2_r;
	// Measurement-limit pin, own synchroniser
	always @(posedge core_clk) begin
		if (reset) begin
			meas1_r <= 1'b0;
			meas2_r <= 1'b0;
		end else begin
			meas1_r <= meas_limit;
			meas2_r <= meas1_r;
		end
	end

	wire [15:0] oc_phase = {4'h0, phase_current} * `OC_PHASE_MUL;
	wire [15:0] oc_limit = {4'h0, base_current_limit} * `OC_LIMIT_MUL;
	wire [11:0] pre_cap  = {2'h0, cap_voltage} * `PRE_CAP_MUL;
	wire [11:0] pre_ksi  = {2'h0, keyswitch_voltage} * `PRE_KSI_MUL;

	// Set conditions, only while the keyswitch is on
	always @* begin
		set_v    = {NF{1'b0}};
		set_v[0] = hw_err_s;
		set_v[1] = hw_oc_s;
		set_v[2] = (oc_phase > oc_limit) | meas2_r;
		set_v[3] = offset_invalid;
		set_v[4] = precharge_done & (pre_cap < pre_ksi);
		set_v[5] = heatsink_temp <= `TEMP_UNDER_SET;
		set_v[6] = heatsink_temp >= `TEMP_OVER_SET;
		set_v[7] = (keyswitch_voltage < `VOLT_UNDER)
			| ((cap_voltage < `VOLT_UNDER) & interlock_on);
		set_v[8] = (keyswitch_voltage > `VOLT_OVER)
			| (cap_voltage > `VOLT_OVER);
		if (!ks_on)
			set_v = {NF{1'b0}};
	end

	// Latch faults; only 15 self-clears, set beats its clear
	always @* begin
		faults_nxt = faults_r | set_v;
		if (!set_v[5] && (heatsink_temp > `TEMP_UNDER_CLR))
			faults_nxt[5] = 1'b0;
		if (!ks_on)
			faults_nxt = {NF{1'b0}};
	end

	// Report lowest-index fault, most restrictive traction
	always @* begin
		code_nxt = 8'h00;
		sub_nxt  = 8'h00;
		trac_nxt = `TRAC_NONE;
		shut_any = 1'b0;
		hold_any = 1'b0;
		wts_any  = 1'b0;
		for (k = NF - 1; k >= 0; k = k - 1) begin
			if (faults_nxt[k]) begin
				code_nxt = code_of(k[3:0]);
				sub_nxt  = sub_of(k[3:0]);
				if (trac_rank(trac_of(k[3:0])) > trac_rank(trac_nxt))
					trac_nxt = trac_of(k[3:0]);
				case (steer_of(k[3:0]))
					`STEER_SHUT: shut_any = 1'b1;
					`STEER_HOLD_SHUT: hold_any = 1'b1;
					`STEER_WARN_SHUT: wts_any = 1'b1;
					default: shut_any = shut_any;
				endcase
			end
		end
	end

	wire timer_done = (timer_r == 16'h0000) | traction_stopped;

	// Steer action, worst action wins
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				if (hold_any)
					state_nxt = ST_HOLD;
				else if (wts_any)
					state_nxt = ST_WARN;
			end
			ST_WARN: begin
				if (timer_done)
					state_nxt = ST_SHUT;
				else if (hold_any)
					state_nxt = ST_HOLD;
			end
			ST_HOLD: begin
				if (timer_done)
					state_nxt = ST_SHUT;
			end
			ST_SHUT: state_nxt = ST_SHUT;
			default: state_nxt = ST_RUN;
		endcase
		if (shut_any)
			state_nxt = ST_SHUT;
		if (!ks_on)
			state_nxt = ST_RUN;
	end

	// Millisecond tick; shortened through MS_CYCLES in simulation
	always @(posedge core_clk) begin
		if (reset) begin
			tick_cnt_r <= {CNT_W{1'b0}};
			tick_r     <= 1'b0;
		end else if (tick_cnt_r == MS_CYCLES[CNT_W-1:0] - 1'b1) begin
			tick_cnt_r <= {CNT_W{1'b0}};
			tick_r     <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
			tick_r     <= 1'b0;
		end
	end

	// Fault steering timer, loaded when a delayed shutdown begins
	always @(posedge core_clk) begin
		if (reset)
			timer_r <= 16'h0000;
		else if (state_r == ST_RUN)
			timer_r <= timeout_r;
		else if (tick_r && timer_r != 16'h0000)
			timer_r <= timer_r - 1'b1;
	end

	// Fault state, report, steering outputs and emergency message
	always @(posedge core_clk) begin
		if (reset) begin
			faults_r               <= {NF{1'b0}};
			state_r                <= ST_RUN;
			steer_enable_r         <= 1'b0;
			hold_position_r        <= 1'b0;
			fault_output_r         <= 1'b0;
			fault_code_r           <= 8'h00;
			sub_code_r             <= 8'h00;
			traction_action_code_r <= `TRAC_NONE;
			error_register_r       <= 1'b0;
			emcy_valid_r           <= 1'b0;
		end else begin
			faults_r               <= faults_nxt;
			state_r                <= state_nxt;
			steer_enable_r         <= ks_on & (state_nxt == ST_RUN || state_nxt == ST_WARN);
			hold_position_r        <= ks_on & (state_nxt == ST_HOLD);
			fault_output_r         <= ks_on & (state_nxt != ST_SHUT);
			fault_code_r           <= code_nxt;
			sub_code_r             <= sub_nxt;
			traction_action_code_r <= trac_nxt;
			error_register_r       <= |faults_nxt;
			emcy_valid_r           <= |(faults_nxt ^ faults_r);
		end
	end

	// Interrupt events: fault set, fault clear, shutdown entered
	always @* begin
		irq_ev = 3'h0;
		irq_ev[`IRQ_SET_BIT]  = |(faults_nxt & ~faults_r);
		irq_ev[`IRQ_CLR_BIT]  = |(faults_r & ~faults_nxt);
		irq_ev[`IRQ_SHUT_BIT] = (state_nxt == ST_SHUT) & (state_r != ST_SHUT);
	end

	wire wr_clr = reg_wr & (reg_addr == `REG_IRQ_CLEAR);

	// Register writes; an event beats a clear in the same cycle
	always @(posedge core_clk) begin
		if (reset) begin
			timeout_r  <= `TIMEOUT_RST;
			irq_en_r   <= `IRQ_EN_RST;
			irq_stat_r <= 3'h0;
			irq_r      <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == `REG_TIMEOUT)
				timeout_r <= reg_wdata[15:0];
			if (reg_wr && reg_addr == `REG_IRQ_ENABLE)
				irq_en_r <= reg_wdata[IRQ_W_L:0];
			irq_stat_r <= (irq_stat_r & ~(wr_clr ? reg_wdata[IRQ_W_L:0] : 3'h0)) | irq_ev;
			irq_r      <= |(((irq_stat_r & ~(wr_clr ? reg_wdata[IRQ_W_L:0] : 3'h0)) | irq_ev) & irq_en_r);
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always @(posedge core_clk) begin
		if (reset)
			reg_rdata_r <= 32'h00000000;
		else if (reg_rd) begin
			case (reg_addr)
				`REG_FAULTS: reg_rdata_r <= {23'h000000, faults_r};
				`REG_REPORT: reg_rdata_r <= {12'h000, state_r, traction_action_code_r,
					sub_code_r, fault_code_r};
				`REG_TIMEOUT: reg_rdata_r <= {16'h0000, timeout_r};
				`REG_IRQ_STATUS: reg_rdata_r <= {29'h00000000, irq_stat_r};
				`REG_IRQ_ENABLE: reg_rdata_r <= {29'h00000000, irq_en_r};
				default: reg_rdata_r <= 32'h00000000;
			endcase
		end else
			reg_rdata_r <= 32'h00000000;
	end

endmodule // steer_fault_supervisor

// ===== steer_fault_supervisor_asserts.sv
// Port checker for the steering fault supervisor.
// Assumes one clock, core_clk, and a synchronous active-high reset.
`timescale 1ns/1ps
`include "steer_fault_defines.vh"

module steer_fault_supervisor_asserts (
	// Clock, reset and register read side
	input wire        core_clk,
	input wire        reset,
	input wire        reg_rd,
	input wire [31:0] reg_rdata_r,
	// Key and traction feedback
	input wire        keyswitch_input,
	input wire        traction_stopped,
	// Steering and report outputs
	input wire        steer_enable_r,
	input wire        fault_output_r,
	input wire [7:0]  fault_code_r,
	input wire [7:0]  sub_code_r,
	input wire [1:0]  traction_action_code_r,
	input wire        error_register_r,
	input wire        emcy_valid_r
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// A reported code other than the two heat faults means a shutdown fault
	sequence s_shut_code;
		error_register_r && fault_code_r != 8'h0f && fault_code_r != 8'h10;
	endsequence
	sequence s_temp_stop;
		fault_code_r == 8'h10 && traction_stopped;
	endsequence

	property p_err_flag; error_register_r == (fault_code_r != 8'h00); endproperty
	property p_trac_none; !error_register_r |-> traction_action_code_r == `TRAC_NONE; endproperty
	property p_emcy; $changed(error_register_r) |-> emcy_valid_r; endproperty
	property p_shut; s_shut_code |-> !fault_output_r && !steer_enable_r; endproperty
	property p_shut_trac; s_shut_code |-> traction_action_code_r == `TRAC_STOP; endproperty
	property p_sub; fault_code_r inside {8'h0b, 8'h0e, 8'h11} |-> sub_code_r == 8'h01; endproperty
	property p_warn;
		keyswitch_input[*5] ##0 (fault_code_r == 8'h0f && traction_action_code_r == `TRAC_NOACT)
			|-> steer_enable_r && fault_output_r;
	endproperty
	property p_warn_wait;
		$rose(error_register_r) && fault_code_r == 8'h10 && !traction_stopped |-> steer_enable_r;
	endproperty
	property p_stop_done; s_temp_stop[*2] |-> ##[0:3] !fault_output_r; endproperty
	property p_rdata; !$past(reg_rd) |-> reg_rdata_r == 32'h0; endproperty

	a_err_flag: assert property (p_err_flag) else $error("fault flag and code disagree");
	a_trac_none: assert property (p_trac_none) else $error("traction code set without fault");
	a_emcy: assert property (p_emcy) else $error("no message on fault change");
	a_shut: assert property (p_shut) else $error("steering kept on shutdown fault");
	a_shut_trac: assert property (p_shut_trac) else $error("shutdown fault not stopping traction");
	a_sub: assert property (p_sub) else $error("sub-code not one");
	a_warn: assert property (p_warn) else $error("warning fault stopped steering");
	a_warn_wait: assert property (p_warn_wait) else $error("heat fault shut down early");
	a_stop_done: assert property (p_stop_done) else $error("no shutdown after traction stop");
	a_rdata: assert property (p_rdata) else $error("read data outside read slot");
endmodule // steer_fault_supervisor_asserts

bind steer_fault_supervisor steer_fault_supervisor_asserts u_steer_fault_supervisor_asserts (
	.core_clk, .reset, .reg_rd, .reg_rdata_r, .keyswitch_input, .traction_stopped, .steer_enable_r,
	.fault_output_r, .fault_code_r, .sub_code_r, .traction_action_code_r, .error_register_r, .emcy_valid_r);

// ===== steer_fault_supervisor_test.sv
// Testbench for the steering fault supervisor with a traction stand-in.
// Assumes a 1 ms tick of 10 cycles.
`timescale 1ns/1ps
`include "steer_fault_defines.vh"

module steer_fault_supervisor_test;
	reg                core_clk, reset, reg_wr, reg_rd, slow;
	reg         [3:0]  reg_addr;
	reg         [31:0] reg_wdata, d;
	reg                hw_error, hw_overcurrent, meas_limit, keyswitch_input;
	reg                offset_invalid, precharge_done, interlock_on;
	reg         [11:0] phase_current, base_current_limit;
	reg         [9:0]  cap_voltage, keyswitch_voltage;
	reg signed  [7:0]  heatsink_temp;
	wire        [31:0] reg_rdata_r;
	wire        [7:0]  fault_code_r, sub_code_r;
	wire        [1:0]  traction_action_code_r;
	wire               traction_stopped, steer_enable_r, hold_position_r, fault_output_r;
	wire               error_register_r, emcy_valid_r, irq_r;
	integer            n_fail, tests_run, i;
	localparam [79:0]  CODES = 80'h0c_12_11_10_0f_0e_0d_0c_0c_0b;
	localparam [79:0]  SUBS  = 80'h05_00_01_00_00_01_00_05_00_01;

	steer_fault_supervisor #(.MS_CYCLES(10)) u_steer_fault_supervisor (.core_clk, .reset, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .hw_error, .hw_overcurrent, .meas_limit, .keyswitch_input,
		.phase_current, .base_current_limit, .offset_invalid, .precharge_done, .cap_voltage, .keyswitch_voltage,
		.interlock_on, .heatsink_temp, .traction_stopped, .steer_enable_r, .hold_position_r, .fault_output_r,
		.fault_code_r, .sub_code_r, .traction_action_code_r, .error_register_r, .emcy_valid_r, .irq_r);
	traction_model u_traction_model (.core_clk, .reset, .traction_action_code(traction_action_code_r),
		.slow, .stopped_r(traction_stopped));

	// 200 MHz clock
	initial begin
		core_clk = 1'h0;
		forever #2.5 core_clk = ~core_clk;
	end

	task close_out;
		begin
			$display("checks %0d mismatches %0d", tests_run, n_fail);
			if (n_fail == 0 && tests_run > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask

	task chk(input [31:0] got, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask

	task wr(input [3:0] a, input [31:0] v);
		begin
			@(posedge core_clk);
			reg_addr <= a;
			reg_wdata <= v;
			reg_wr <= 1'h1;
			@(posedge core_clk);
			reg_wr <= 1'h0;
		end
	endtask

	task rd(input [3:0] a, output [31:0] v);
		begin
			@(posedge core_clk);
			reg_addr <= a;
			reg_rd <= 1'h1;
			@(posedge core_clk);
			reg_rd <= 1'h0;
			#1;
			v = reg_rdata_r;
		end
	endtask

	// Healthy machine: 24 V, 25 degC, no current
	task normal;
		begin
			{hw_error, hw_overcurrent, meas_limit, offset_invalid} <= 4'h0;
			{precharge_done, interlock_on} <= 2'h3;
			phase_current <= 12'h000;
			base_current_limit <= 12'h064;
			cap_voltage <= 10'h0f0;
			keyswitch_voltage <= 10'h0f0;
			heatsink_temp <= 8'sh19;
		end
	endtask

	task set_fault(input integer f);
		begin
			@(posedge core_clk);
			case (f)
				0: hw_error <= 1'h1;
				1: hw_overcurrent <= 1'h1;
				2: phase_current <= 12'h079;
				3: offset_invalid <= 1'h1;
				4: cap_voltage <= 10'h0b3;
				5: heatsink_temp <= 8'shd8;
				6: heatsink_temp <= 8'sh5f;
				7: keyswitch_voltage <= 10'h077;
				8: cap_voltage <= 10'h28b;
				default: meas_limit <= 1'h1;
			endcase
		end
	endtask

	// Bounded waits; running out ends the run
	task wait_emcy;
		integer k;
		begin
			@(posedge core_clk);
			#1;
			for (k = 0; k < 40 && emcy_valid_r !== 1'h1; k = k + 1) begin
				@(posedge core_clk);
				#1;
			end
			if (emcy_valid_r !== 1'h1) begin
				n_fail = n_fail + 1;
				close_out;
			end
		end
	endtask

	task wait_low;
		integer k;
		begin
			for (k = 0; k < 60 && fault_output_r !== 1'h0; k = k + 1) begin
				@(posedge core_clk);
				#1;
			end
			chk(fault_output_r, 1'h0);
			if (fault_output_r !== 1'h0)
				close_out;
		end
	endtask

	// Power cycle clears latched faults and raises the fault output again
	task key_cycle;
		begin
			@(posedge core_clk);
			keyswitch_input <= 1'h0;
			normal;
			wait_emcy;
			chk(error_register_r, 1'h0);
			chk(traction_action_code_r, `TRAC_NONE);
			@(posedge core_clk);
			keyswitch_input <= 1'h1;
			repeat (5) @(posedge core_clk);
			#1;
			chk(fault_output_r, 1'h1);
		end
	endtask

	// Main sequence
	initial begin
		n_fail = 0;
		tests_run = 0;
		{reset, keyswitch_input} = 2'h3;
		{reg_wr, reg_rd, slow} = 3'h0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		normal;
		repeat (3) @(posedge core_clk);
		reset <= 1'h0;
		repeat (5) @(posedge core_clk);
		rd(`REG_TIMEOUT, d);
		chk(d, 32'h3e8);
		@(posedge core_clk);
		phase_current <= 12'h078;
		repeat (5) @(posedge core_clk);
		#1;
		chk(error_register_r, 1'h0);
		wr(`REG_IRQ_ENABLE, 32'h1);
		for (i = 0; i < 10; i = i + 1) begin
			set_fault(i);
			wait_emcy;
			chk(fault_code_r, CODES[i*8 +: 8]);
			chk(sub_code_r, SUBS[i*8 +: 8]);
			chk(traction_action_code_r, i == 5 ? `TRAC_NOACT : `TRAC_STOP);
			chk(fault_output_r, i == 5 || i == 6);
			chk(steer_enable_r, i == 5 || i == 6);
			chk(hold_position_r, 1'h0);
			rd(`REG_REPORT, d);
			chk(d[19:16], i == 5 ? 4'h3 : i == 6 ? 4'h5 : 4'hd);
			rd(`REG_FAULTS, d);
			chk(d, i == 9 ? 32'h4 : 32'h1 << i);
			chk(irq_r, 1'h1);
			wr(`REG_IRQ_CLEAR, 32'h1);
			@(posedge core_clk);
			#1;
			chk(irq_r, 1'h0);
			if (i == 6)
				wait_low;
			key_cycle;
		end
		$display("fault table done");
		// Masked events, enable, clear, write-only and unmapped reads
		rd(`REG_IRQ_STATUS, d);
		chk(d, 32'h6);
		chk(irq_r, 1'h0);
		wr(`REG_IRQ_ENABLE, 32'h7);
		@(posedge core_clk);
		#1;
		chk(irq_r, 1'h1);
		rd(`REG_IRQ_ENABLE, d);
		chk(d, 32'h7);
		wr(`REG_IRQ_CLEAR, 32'h7);
		@(posedge core_clk);
		#1;
		chk(irq_r, 1'h0);
		rd(`REG_IRQ_CLEAR, d);
		chk(d, 32'h0);
		rd(4'hf, d);
		chk(d, 32'h0);
		$display("interrupt and register test done");
		// Traction never stops: the 2 ms timer forces the shutdown
		wr(`REG_TIMEOUT, 32'h2);
		@(posedge core_clk);
		slow <= 1'h1;
		set_fault(6);
		wait_emcy;
		repeat (8) @(posedge core_clk);
		#1;
		chk(steer_enable_r, 1'h1);
		wait_low;
		key_cycle;
		$display("timeout test done");
		// Undertemperature clears itself only above -35 degC
		set_fault(5);
		wait_emcy;
		@(posedge core_clk);
		heatsink_temp <= 8'shdd;
		repeat (4) @(posedge core_clk);
		#1;
		chk(error_register_r, 1'h1);
		@(posedge core_clk);
		heatsink_temp <= 8'shde;
		wait_emcy;
		chk(error_register_r, 1'h0);
		$display("undertemperature test done");
		close_out;
	end
endmodule // steer_fault_supervisor_test

// ===== traction_model.sv
// Traction motor controller stand-in: reports stopped once told to stop.
// Assumes the supervisor's traction code arrives on core_clk.
`timescale 1ns/1ps
`include "steer_fault_defines.vh"

module traction_model (
	// Clock and reset
	input wire       core_clk,
	input wire       reset,
	// Supervisor side
	input wire [1:0] traction_action_code,
	input wire       slow,
	output reg       stopped_r
);
	reg [11:0] coast_r;

	// Coasts down only under a stop code; slow mode outlasts any short timer
	always @(posedge core_clk) begin
		if (reset || traction_action_code != `TRAC_STOP) begin
			coast_r <= 12'h000;
			stopped_r <= 1'h0;
		end else begin
			coast_r <= coast_r + {11'h000, coast_r != 12'hfff};
			stopped_r <= coast_r >= (slow ? 12'hfa0 : 12'h008);
		end
	end
endmodule // traction_model
